// file: cts_consts.svh
// Constants for the capacitive touch sense control block.
// Assumes inclusion by the design file and the bench only; definitions only.
`ifndef CTS_CONSTS_SVH
`define CTS_CONSTS_SVH
`define CTS_ADDR_CTRL0 12'h000
`define CTS_ADDR_CTRL1 12'h004
`define CTS_ADDR_T1CTRL 12'h008
`define CTS_ADDR_OPTION 12'h00C
`define CTS_ADDR_T0CNT 12'h010
`define CTS_ADDR_T1CNT 12'h014
`define CTS_C0_ENABLE 7
`define CTS_C0_RANGE_HI 3
`define CTS_C0_RANGE_LO 2
`define CTS_C0_DIR 1
`define CTS_C0_T0XPICK 0
`define CTS_C1_CH_HI 2
`define CTS_T1_CS_HI 7
`define CTS_T1_CS_LO 6
`define CTS_T1_GE 5
`define CTS_T1_ON 0
`define CTS_OPT_TIMER0_CLOCK_SOURCE 0
`define CTS_T1CS_SENSE 2'h3
`define CTS_CH_W 3
`define CTS_NUM_CH 8
`define CTS_T0_W 8
`define CTS_T1_W 16
`endif

// file: cts_osc_sync.sv
// Synchroniser and rising-edge detector for the sensing oscillator.
// Assumes the oscillator is much slower than core_clk.
`timescale 1ns/1ps
module cts_osc_sync (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic oscIn,
  output logic oscLevel,
  output logic oscRise
);
  logic meta;
  logic s2;
  logic s3;
  logic stable;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      meta <= oscIn;
      s2 <= meta;
      s3 <= s2;
    end
  end
  // A change counts only once stages two and three agree
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stable <= 1'b0;
      oscRise <= 1'b0;
    end else begin
      oscRise <= 1'b0;
      if (s2 == s3 && s3 != stable) begin
        stable <= s3;
        oscRise <= s3;
      end
    end
  end
  assign oscLevel = stable;
endmodule

// file: cts_pad_model.sv
// Behavioural pad and sensing oscillator seen from the control block.
// Assumes the control block drives oscRun, range and pad select.
`timescale 1ns/1ps
module cts_pad_model (
  input wire logic oscRun,
  input wire cts_pkg::cts_range_e oscCurrentRange,
  input wire logic [7:0] senseInputPin,
  input wire logic padLoaded,
  output logic oscIn,
  output logic oscSourcing
);
  import cts_pkg::*;
  int half;
  initial oscIn = 1'b0;
  // Rising ramp means current flows out of the pad
  assign oscSourcing = oscIn;
  // Stands still when off or when no pad is joined
  always begin
    if (oscRun !== 1'b1 || senseInputPin == 8'h00) begin
      @(oscRun or senseInputPin);
    end else begin
      // Step in ns is odd only for medium range unloaded and for low or high range loaded
      half = (5 - int'(oscCurrentRange)) * 23 + (padLoaded ? 31 : 0);
      #(half);
      if (oscRun === 1'b1) oscIn = ~oscIn;
    end
  end
endmodule

// file: cts_pkg.sv
// Types shared by the touch sense control files.
// Assumes cts_consts.svh is on the include path.
package cts_pkg;
  typedef enum logic [1:0] {
    CTS_RNG_OFF,
    CTS_RNG_LOW,
    CTS_RNG_MED,
    CTS_RNG_HIGH
  } cts_range_e;
  typedef logic [2:0] cts_chan_t;
endpackage

// file: cts_touch_sense.sv
// Capacitive touch sense control: pad select, range, timer clocking.
// Assumes an APB master on core_clk and an analog oscillator outside.
// Operation
// - Eight sense inputs, only one joined to the oscillator at once.
// - Three-bit channel field picks the pin while module is enabled.
// - Read-only flag shows oscillator sourcing or sinking current.
// - Two-bit range field picks one of three oscillator currents.
// - Oscillator can clock the 8-bit Timer0 or 16-bit Timer1.
// - External pick set and Timer0 source clear route oscillator to Timer0.
// - Timer1 source field equal to 11 clocks Timer1 from oscillator.
// - Timer1 off when on bit clear; gate enable makes gate control counting.
// - Range 00 off, 01 low, 10 medium, 11 high.
// - Enable bit runs the module; clear shuts it off without current.
// - With enable clear no input is connected, channel field ignored.
`timescale 1ns/1ps
`include "cts_consts.svh"
module cts_touch_sense (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscIn,
  input wire logic oscSourcing,
  input wire logic timer0ExtPin,
  input wire logic timer1Gate,
  output logic [7:0] senseInputPin,
  output logic oscRun,
  output cts_pkg::cts_range_e oscCurrentRange,
  output logic timer0FromSense,
  output logic timer1FromSense,
  output logic [7:0] timer0Count,
  output logic [15:0] timer1Count
);
  import cts_pkg::*;

  logic senseModuleEnable;
  cts_range_e oscRange;
  logic timer0ExternalClockPick;
  cts_chan_t senseChannelSelect;
  logic [1:0] timer1ClockSource;
  logic timer1GateEnable;
  logic timer1On;
  logic timer0ClockSource;
  logic oscLevel;
  logic oscRise;
  logic dirMeta;
  logic dirS2;
  logic dirS3;
  logic oscDirectionFlag;
  logic gateMeta;
  logic gateS2;
  logic gateS3;
  logic gateLevel;
  logic extMeta;
  logic extS2;
  logic extS3;
  logic extLevel;
  logic extRise;
  logic wrEn;
  logic rdEn;
  logic t1Counting;
  logic t0Tick;
  logic t1Tick;
  logic [31:0] next_prdata;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // Single-cycle access phase keeps the slave simple and deterministic
  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      senseModuleEnable <= 1'b0;
      oscRange <= CTS_RNG_OFF;
      timer0ExternalClockPick <= 1'b0;
      senseChannelSelect <= '0;
      timer1ClockSource <= 2'h0;
      timer1GateEnable <= 1'b0;
      timer1On <= 1'b0;
      timer0ClockSource <= 1'b0;
    end else if (wrEn) begin
      if (hit(paddr, `CTS_ADDR_CTRL0)) begin
        senseModuleEnable <= pwdata[`CTS_C0_ENABLE];
        oscRange <= cts_range_e'(pwdata[`CTS_C0_RANGE_HI:`CTS_C0_RANGE_LO]);
        timer0ExternalClockPick <= pwdata[`CTS_C0_T0XPICK];
      end
      if (hit(paddr, `CTS_ADDR_CTRL1)) begin
        senseChannelSelect <= pwdata[`CTS_C1_CH_HI:0];
      end
      if (hit(paddr, `CTS_ADDR_T1CTRL)) begin
        timer1ClockSource <= pwdata[`CTS_T1_CS_HI:`CTS_T1_CS_LO];
        timer1GateEnable <= pwdata[`CTS_T1_GE];
        timer1On <= pwdata[`CTS_T1_ON];
      end
      if (hit(paddr, `CTS_ADDR_OPTION)) begin
        timer0ClockSource <= pwdata[`CTS_OPT_TIMER0_CLOCK_SOURCE];
      end
    end
  end

  // Unmapped addresses answer with an error
  always_comb begin
    pslverr = 1'b0;
    if (wrEn || rdEn) begin
      pslverr = !(hit(paddr, `CTS_ADDR_CTRL0) || hit(paddr, `CTS_ADDR_CTRL1) ||
        hit(paddr, `CTS_ADDR_T1CTRL) || hit(paddr, `CTS_ADDR_OPTION) ||
        hit(paddr, `CTS_ADDR_T0CNT) || hit(paddr, `CTS_ADDR_T1CNT));
    end
  end

  always_comb begin
    next_prdata = 32'h0;
    if (hit(paddr, `CTS_ADDR_CTRL0)) begin
      next_prdata[`CTS_C0_ENABLE] = senseModuleEnable;
      next_prdata[`CTS_C0_RANGE_HI:`CTS_C0_RANGE_LO] = oscRange;
      next_prdata[`CTS_C0_DIR] = oscDirectionFlag;
      next_prdata[`CTS_C0_T0XPICK] = timer0ExternalClockPick;
    end else if (hit(paddr, `CTS_ADDR_CTRL1)) begin
      next_prdata[`CTS_C1_CH_HI:0] = senseChannelSelect;
    end else if (hit(paddr, `CTS_ADDR_T1CTRL)) begin
      next_prdata[`CTS_T1_CS_HI:`CTS_T1_CS_LO] = timer1ClockSource;
      next_prdata[`CTS_T1_GE] = timer1GateEnable;
      next_prdata[`CTS_T1_ON] = timer1On;
    end else if (hit(paddr, `CTS_ADDR_OPTION)) begin
      next_prdata[`CTS_OPT_TIMER0_CLOCK_SOURCE] = timer0ClockSource;
    end else if (hit(paddr, `CTS_ADDR_T0CNT)) begin
      next_prdata[`CTS_T0_W-1:0] = timer0Count;
    end else if (hit(paddr, `CTS_ADDR_T1CNT)) begin
      next_prdata[`CTS_T1_W-1:0] = timer1Count;
    end
  end

  // Read data is registered in the setup cycle so it stands in the access phase
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Pad mux: one-hot only while enabled, nothing otherwise
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      senseInputPin <= 8'h00;
    end else if (senseModuleEnable) begin
      senseInputPin <= 8'h01 << senseChannelSelect;
    end else begin
      senseInputPin <= 8'h00;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      oscRun <= 1'b0;
      oscCurrentRange <= CTS_RNG_OFF;
    end else begin
      oscRun <= senseModuleEnable && (oscRange != CTS_RNG_OFF);
      oscCurrentRange <= senseModuleEnable ? oscRange : CTS_RNG_OFF;
    end
  end

  cts_osc_sync oscSync (
    .core_clk(core_clk),
    .reset(reset),
    .oscIn(oscIn),
    .oscLevel(oscLevel),
    .oscRise(oscRise)
  );

  // Three-stage capture of the asynchronous direction, gate and T0 pin levels
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dirMeta <= 1'b0;
      dirS2 <= 1'b0;
      dirS3 <= 1'b0;
      oscDirectionFlag <= 1'b0;
      gateMeta <= 1'b0;
      gateS2 <= 1'b0;
      gateS3 <= 1'b0;
      gateLevel <= 1'b0;
      extMeta <= 1'b0;
      extS2 <= 1'b0;
      extS3 <= 1'b0;
      extLevel <= 1'b0;
    end else begin
      dirMeta <= oscSourcing;
      dirS2 <= dirMeta;
      dirS3 <= dirS2;
      if (dirS2 == dirS3) begin
        oscDirectionFlag <= dirS3;
      end
      gateMeta <= timer1Gate;
      gateS2 <= gateMeta;
      gateS3 <= gateS2;
      if (gateS2 == gateS3) begin
        gateLevel <= gateS3;
      end
      extMeta <= timer0ExtPin;
      extS2 <= extMeta;
      extS3 <= extS2;
      if (extS2 == extS3) begin
        extLevel <= extS3;
      end
    end
  end
  assign extRise = (extS2 == extS3) && extS3 && !extLevel;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer0FromSense <= 1'b0;
      timer1FromSense <= 1'b0;
    end else begin
      // Sense counting wants the clock-source bit clear; set leaves Timer0 on its pin
      timer0FromSense <= !timer0ClockSource && timer0ExternalClockPick;
      timer1FromSense <= (timer1ClockSource == `CTS_T1CS_SENSE);
    end
  end

  // Other Timer1 clock sources are outside this block; Timer0 counts the sense path or its pin here
  assign t1Counting = timer1On && (!timer1GateEnable || gateLevel);
  assign t0Tick = timer0FromSense ? oscRise : (timer0ClockSource && extRise);
  assign t1Tick = timer1FromSense && oscRise && t1Counting;

  // Software loads a counter by writing it; a tick in that cycle is dropped
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer0Count <= 8'h00;
    end else if (wrEn && hit(paddr, `CTS_ADDR_T0CNT)) begin
      timer0Count <= pwdata[`CTS_T0_W-1:0];
    end else if (t0Tick) begin
      timer0Count <= timer0Count + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer1Count <= 16'h0000;
    end else if (wrEn && hit(paddr, `CTS_ADDR_T1CNT)) begin
      timer1Count <= pwdata[`CTS_T1_W-1:0];
    end else if (t1Tick) begin
      timer1Count <= timer1Count + 16'h0001;
    end
  end

  mux_off_a: assert property (@(posedge core_clk) disable iff (reset)
    !senseModuleEnable |=> senseInputPin == 8'h00) else $error("pad on while off");
  mux_onehot_a: assert property (@(posedge core_clk) disable iff (reset)
    senseModuleEnable |=> $onehot(senseInputPin)) else $error("mux not one-hot");
  mux_chan_a: assert property (@(posedge core_clk) disable iff (reset)
    senseModuleEnable && $stable(senseChannelSelect) |=>
    senseInputPin[$past(senseChannelSelect)]) else $error("wrong pad");
  range_off_a: assert property (@(posedge core_clk) disable iff (reset)
    oscRange == CTS_RNG_OFF |=> !oscRun) else $error("osc runs in off range");
  enable_off_a: assert property (@(posedge core_clk) disable iff (reset)
    !senseModuleEnable |=> !oscRun && oscCurrentRange == CTS_RNG_OFF)
    else $error("osc runs while disabled");
  t0_route_a: assert property (@(posedge core_clk) disable iff (reset)
    !timer0ClockSource && timer0ExternalClockPick |=> timer0FromSense)
    else $error("timer0 not routed");
  t1_route_a: assert property (@(posedge core_clk) disable iff (reset)
    timer1ClockSource == `CTS_T1CS_SENSE |=> timer1FromSense)
    else $error("timer1 not routed");
  t1_off_a: assert property (@(posedge core_clk) disable iff (reset)
    !timer1On && !wrEn |=> $stable(timer1Count)) else $error("timer1 counts off");
  t1_count_a: assert property (@(posedge core_clk) disable iff (reset)
    t1Tick && !wrEn |=> timer1Count == $past(timer1Count) + 16'h0001)
    else $error("timer1 missed tick");
  sync_rise_a: assert property (@(posedge core_clk) disable iff (reset)
    oscRise |=> !oscRise) else $error("double count");
  dir_flag_a: assert property (@(posedge core_clk) disable iff (reset)
    dirS2 == dirS3 |=> oscDirectionFlag == $past(dirS3)) else $error("flag stale");

  // Hold checks catch a timer that counts while its gate or route should stop it
  t1_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    timer1On && timer1GateEnable && !gateLevel && !wrEn |=> $stable(timer1Count))
    else $error("timer1 counts while gated");
  t0_count_a: assert property (@(posedge core_clk) disable iff (reset)
    t0Tick && !wrEn |=> timer0Count == $past(timer0Count) + 8'h01)
    else $error("timer0 missed tick");
  t0_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !timer0FromSense && !timer0ClockSource && !wrEn |=> $stable(timer0Count))
    else $error("timer0 counts on internal clock");
  osc_level_a: assert property (@(posedge core_clk) disable iff (reset)
    oscRise |-> oscLevel) else $error("rise without high level");
endmodule

// file: cts_touch_sense_tb.sv
// Self-checking bench for the touch sense control block.
// Assumes the design files and the pad model are compiled first.
`timescale 1ns/1ps
`include "cts_consts.svh"
module cts_touch_sense_tb;
  import cts_pkg::*;
  logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d0, d1, seed = 32'h4E;
  logic pready, pslverr, er, oscIn, oscSourcing, oscRun, timer1Gate = 0, loaded = 0;
  logic timer0FromSense, timer1FromSense, pick = 0;
  logic [1:0] t1cs, rng;
  logic [7:0] senseInputPin, timer0Count;
  logic [15:0] timer1Count;
  cts_range_e oscCurrentRange;
  int miscompares = 0, samplesChecked = 0, cycles = 0, edges = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge oscIn) edges++;
  cts_touch_sense dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscIn(oscIn), .oscSourcing(oscSourcing), .timer0ExtPin(1'b0),
    .timer1Gate(timer1Gate), .senseInputPin(senseInputPin), .oscRun(oscRun),
    .oscCurrentRange(oscCurrentRange), .timer0FromSense(timer0FromSense),
    .timer1FromSense(timer1FromSense), .timer0Count(timer0Count), .timer1Count(timer1Count));
  cts_pad_model pad (.oscRun(oscRun), .oscCurrentRange(oscCurrentRange),
    .senseInputPin(senseInputPin), .padLoaded(loaded), .oscIn(oscIn), .oscSourcing(oscSourcing));
  task automatic conclude();
    if (miscompares == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samplesChecked++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", n, x, g);
    end
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] expCount(input logic go, input int w);
    return go ? edges % (1 << w) : 0;
  endfunction
  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    // A slave that never raises pready is ended only by the bench timeout
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Counters are cleared while the oscillator stands, so no tick is lost
  task automatic measure(input logic [1:0] r);
    apb(1, `CTS_ADDR_CTRL0, {24'h0, 1'b1, 5'h0, 1'b0, pick});
    repeat (12) @(posedge core_clk);
    apb(1, `CTS_ADDR_T0CNT, 0);
    apb(1, `CTS_ADDR_T1CNT, 0);
    edges = 0;
    apb(1, `CTS_ADDR_CTRL0, {24'h0, 1'b1, 3'h0, r, 1'b0, pick});
    repeat (300) @(posedge core_clk);
    apb(1, `CTS_ADDR_CTRL0, {24'h0, 1'b1, 5'h0, 1'b0, pick});
    repeat (12) @(posedge core_clk);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 0;
    for (int a = 0; a < 28; a += 4) begin
      apb(0, a[11:0], 0);
      chk("reset read", 0, rd);
      chk("slave error", a == 24, er);
    end
    for (int i = 0; i < 24; i++) begin
      d0 = xs();
      d1 = xs();
      if (i < 8) begin
        d0[7] = 1;
        d1[2:0] = i[2:0];
      end
      apb(1, `CTS_ADDR_CTRL1, d1);
      apb(1, `CTS_ADDR_CTRL0, d0);
      repeat (2) @(posedge core_clk);
      #1;
      chk("pins", d0[7] ? 8'h01 << d1[2:0] : 0, senseInputPin);
      chk("range", d0[7] ? d0[3:2] : 0, oscCurrentRange);
      chk("run", d0[7] && d0[3:2] != 0, oscRun);
      apb(0, `CTS_ADDR_CTRL1, 0);
      chk("channel", d1[2:0], rd);
      apb(0, `CTS_ADDR_CTRL0, 0);
      chk("ctrl0", d0 & 32'h8D, rd & 32'hFFFFFFFD);
    end
    for (int k = 0; k < 8; k++) begin
      d0 = xs();
      rng = (d0[3:2] == 0) ? 2'h2 : d0[3:2];
      pick = k[2];
      t1cs = (k == 1) ? 2'h1 : 2'h3;
      timer1Gate <= k[2];
      apb(1, `CTS_ADDR_OPTION, {31'h0, k[1]});
      apb(1, `CTS_ADDR_T1CTRL, {24'h0, t1cs, k[1], 4'h0, k[0]});
      measure(rng);
      chk("t1 route", t1cs == 2'h3, timer1FromSense);
      chk("t0 route", k[2] & !k[1], timer0FromSense);
      apb(0, `CTS_ADDR_T1CNT, 0);
      chk("t1 count", expCount(t1cs == 2'h3 && k[0] && (!k[1] || k[2]), 16), rd);
      apb(0, `CTS_ADDR_T0CNT, 0);
      chk("t0 count", expCount(k[2] & !k[1], 8), rd);
      apb(0, `CTS_ADDR_CTRL0, 0);
      chk("direction", oscSourcing, rd[1]);
    end
    measure(2'h2);
    apb(0, `CTS_ADDR_T1CNT, 0);
    d0 = rd;
    loaded = 1;
    measure(2'h2);
    apb(0, `CTS_ADDR_T1CNT, 0);
    chk("loaded lower", 1, rd < d0);
    d1 = (d0 + rd) >> 1;
    chk("threshold", 1, rd < d1 && d1 < d0);
    // Reset in mid-run must clear counts and controls again
    reset <= 1;
    repeat (3) @(posedge core_clk);
    reset <= 0;
    chk("pins after reset", 0, senseInputPin);
    apb(0, `CTS_ADDR_T1CNT, 0);
    chk("count after reset", 0, rd);
    apb(0, `CTS_ADDR_CTRL0, 0);
    chk("ctrl0 after reset", 0, rd & 32'hFFFFFFFD);
    conclude();
  end
endmodule
